/* File: rtl/pim_pkg.sv */
// Package for the power-management interrupt mask block.
// Assumes a byte-wide register port decoded from the serial control link.
package pim_pkg;
  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [7:0] PIM_OFS_TOP_FIRST = 8'h20;  // First top-level mask
  localparam logic [7:0] PIM_OFS_TOP_SECOND = 8'h21; // Second top-level mask
  localparam logic [7:0] PIM_OFS_REGULATOR = 8'h22;  // Buck mask
  // ****************************************
  // Field positions, first top-level mask
  // ****************************************
  localparam int PIM_BIT_POWER_OK = 7;
  localparam int PIM_BIT_SYNC_CLK = 4;
  localparam int PIM_BIT_HOT_DIE = 2;
  localparam int PIM_BIT_LOAD_SAMPLE = 0;
  // Writable bits of first register (reserved 6:5, 3, 1 are R/W too)
  localparam logic [7:0] PIM_WMASK_TOP_FIRST = 8'hff;
  // ****************************************
  // Field positions, second top-level mask
  // ****************************************
  localparam int PIM_BIT_REG_RESET = 0;
  localparam logic [7:0] PIM_WMASK_TOP_SECOND = 8'hfe; // Bit 0 is reloaded only
  localparam logic [7:0] PIM_RST_TOP_SECOND_HI = 8'h00;
  // ****************************************
  // Field positions, buck mask
  // ****************************************
  localparam int PIM_BIT_SW1_FAIL = 7;
  localparam int PIM_BIT_SW1_GOOD = 6;
  localparam int PIM_BIT_SW1_OVERCURRENT = 4;
  localparam int PIM_BIT_SW0_FAIL = 3;
  localparam int PIM_BIT_SW0_GOOD = 2;
  localparam int PIM_BIT_SW0_OVERCURRENT = 0;
  localparam logic [7:0] PIM_WMASK_REGULATOR = 8'hdd; // Bits 5 and 1 read zero
  // Number of event sources
  localparam int PIM_NUM_EVT = 11;
  // Event indices
  localparam int PIM_EV_POWER_OK = 0;
  localparam int PIM_EV_SYNC_CLK = 1;
  localparam int PIM_EV_HOT_DIE = 2;
  localparam int PIM_EV_LOAD_SAMPLE = 3;
  localparam int PIM_EV_REG_RESET = 4;
  localparam int PIM_EV_SW1_FAIL = 5;
  localparam int PIM_EV_SW1_GOOD = 6;
  localparam int PIM_EV_SW1_OVERCURRENT = 7;
  localparam int PIM_EV_SW0_FAIL = 8;
  localparam int PIM_EV_SW0_GOOD = 9;
  localparam int PIM_EV_SW0_OVERCURRENT = 10;
  // Load state machine
  typedef enum logic [1:0] {
    PIM_ST_LOAD = 2'b01,
    PIM_ST_RUN = 2'b10
  } pim_state_t;
endpackage

/* File: rtl/pim_sync.sv */
// Two-flop synchroniser vector for pin-level event inputs.
// Assumes inputs are asynchronous levels; one clock domain.
`timescale 1ns/100ps
module pim_sync
#(
  parameter int WIDTH = 11
)
(
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  // Data
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] meta; // First stage, read only by second
  // ****************************************
  // Two stages
  // ****************************************
  always_ff @(posedge core_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      meta <= '0;
      sync_o <= '0;
    end
    else
    begin
      meta <= async_i;
      sync_o <= meta;
    end
  end
endmodule

/* File: rtl/pim_mask_regs.sv */
// Interrupt mask registers of a power-management device.
// Assumes a decoded byte register port from the serial link, and
// one-time-programmable defaults presented on otp_* before reset release.
// Overview of operation
// - Bit 7 first mask blocks power-ok interrupt
// - Masks never alter the raw status bits
// - Sync clock detect interrupt has mask bit
// - Bit 2 first mask blocks hot die
// - Bit 0 first mask blocks load sample
// - Second mask bit 0 blocks reg reset
// - Reg reset mask reloaded from OTP only
// - Buck bit 7 blocks switcher1 fail interrupt
// - Buck bit 6 blocks switcher1 good interrupt
// - Buck bits 4,3,2,0 block remaining events
`timescale 1ns/100ps
module pim_mask_regs
  import pim_pkg::*;
(
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  // Register port from serial link
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  // OTP defaults
  input wire logic [7:0] otp_top_first_i,
  input wire logic otp_reg_reset_i,
  input wire logic [7:0] otp_regulator_i,
  // Raw event pulses from pins, asynchronous
  input wire logic [pim_pkg::PIM_NUM_EVT-1:0] event_i,
  // Flags and interrupt
  output logic [pim_pkg::PIM_NUM_EVT-1:0] irq_flag_o,
  output logic irq_o,
  output logic [pim_pkg::PIM_NUM_EVT-1:0] event_raw_o
);
  import pim_pkg::*;
  // ****************************************
  // Declarations
  // ****************************************
  pim_state_t state; // Load or run
  logic [7:0] top_event_mask_first; // Mask register 0x20
  logic [7:0] top_event_mask_second; // Mask register 0x21
  logic [7:0] regulator_event_mask; // Mask register 0x22
  logic [PIM_NUM_EVT-1:0] ev_sync; // Synchronised events
  logic [PIM_NUM_EVT-1:0] ev_prev; // Last sample, for edges
  logic [PIM_NUM_EVT-1:0] ev_rise; // New event this cycle
  logic [PIM_NUM_EVT-1:0] ev_block; // Mask per event
  logic [PIM_NUM_EVT-1:0] next_flag; // Next flag value
  logic [PIM_NUM_EVT-1:0] flag_clr; // Clear request, unused source
  logic [7:0] next_rdata; // Read mux
  // ****************************************
  // Input synchroniser
  // ****************************************
  pim_sync #(.WIDTH(PIM_NUM_EVT)) u_sync
  (
    .core_clk_i(core_clk_i),
    .rst_b_i(rst_b_i),
    .async_i(event_i),
    .sync_o(ev_sync)
  );
  // ****************************************
  // Load state after reset
  // ****************************************
  // One cycle to take OTP defaults after release
  always_ff @(posedge core_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      state <= PIM_ST_LOAD;
    end
    else
    begin
      unique case (state)
        PIM_ST_LOAD: state <= PIM_ST_RUN;
        PIM_ST_RUN: state <= PIM_ST_RUN;
        default: state <= PIM_ST_LOAD;
      endcase
    end
  end
  // ****************************************
  // Mask registers
  // ****************************************
  // First top-level mask, OTP then writes
  always_ff @(posedge core_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      top_event_mask_first <= 8'h00;
    end
    else if (state == PIM_ST_LOAD)
    begin
      top_event_mask_first <= otp_top_first_i & PIM_WMASK_TOP_FIRST;
    end
    else if (reg_wr_i && reg_addr_i == PIM_OFS_TOP_FIRST)
    begin
      top_event_mask_first <= reg_wdata_i & PIM_WMASK_TOP_FIRST;
    end
  end
  // Second top-level mask, bit 0 OTP only
  always_ff @(posedge core_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      top_event_mask_second <= PIM_RST_TOP_SECOND_HI;
    end
    else if (state == PIM_ST_LOAD)
    begin
      top_event_mask_second <= PIM_RST_TOP_SECOND_HI;
      top_event_mask_second[PIM_BIT_REG_RESET] <= otp_reg_reset_i;
    end
    else if (reg_wr_i && reg_addr_i == PIM_OFS_TOP_SECOND)
    begin
      top_event_mask_second <= (reg_wdata_i & PIM_WMASK_TOP_SECOND)
        | (top_event_mask_second & ~PIM_WMASK_TOP_SECOND);
    end
  end
  // Buck mask, reserved bits stay zero
  always_ff @(posedge core_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      regulator_event_mask <= 8'h00;
    end
    else if (state == PIM_ST_LOAD)
    begin
      regulator_event_mask <= otp_regulator_i & PIM_WMASK_REGULATOR;
    end
    else if (reg_wr_i && reg_addr_i == PIM_OFS_REGULATOR)
    begin
      regulator_event_mask <= reg_wdata_i & PIM_WMASK_REGULATOR;
    end
  end
  // ****************************************
  // Mask mapping per event
  // ****************************************
  always_comb
  begin
    ev_block[PIM_EV_POWER_OK] = top_event_mask_first[PIM_BIT_POWER_OK];
    ev_block[PIM_EV_SYNC_CLK] = top_event_mask_first[PIM_BIT_SYNC_CLK];
    ev_block[PIM_EV_HOT_DIE] = top_event_mask_first[PIM_BIT_HOT_DIE];
    ev_block[PIM_EV_LOAD_SAMPLE] = top_event_mask_first[PIM_BIT_LOAD_SAMPLE];
    ev_block[PIM_EV_REG_RESET] = top_event_mask_second[PIM_BIT_REG_RESET];
    ev_block[PIM_EV_SW1_FAIL] = regulator_event_mask[PIM_BIT_SW1_FAIL];
    ev_block[PIM_EV_SW1_GOOD] = regulator_event_mask[PIM_BIT_SW1_GOOD];
    ev_block[PIM_EV_SW1_OVERCURRENT] = regulator_event_mask[PIM_BIT_SW1_OVERCURRENT];
    ev_block[PIM_EV_SW0_FAIL] = regulator_event_mask[PIM_BIT_SW0_FAIL];
    ev_block[PIM_EV_SW0_GOOD] = regulator_event_mask[PIM_BIT_SW0_GOOD];
    ev_block[PIM_EV_SW0_OVERCURRENT] = regulator_event_mask[PIM_BIT_SW0_OVERCURRENT];
  end
  // ****************************************
  // Edge detect and flags
  // ****************************************
  // Previous sample of synchronised events
  always_ff @(posedge core_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      ev_prev <= '0;
    end
    else
    begin
      ev_prev <= ev_sync;
    end
  end
  assign ev_rise = ev_sync & ~ev_prev;
  // Flag clear request tied off; no clear path here beyond reset
  assign flag_clr = '0;
  // Set only when unmasked, set beats clear
  assign next_flag = (irq_flag_o & ~flag_clr) | (ev_rise & ~ev_block);
  always_ff @(posedge core_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      irq_flag_o <= '0;
      irq_o <= 1'b0;
    end
    else
    begin
      irq_flag_o <= next_flag;
      irq_o <= |next_flag;
    end
  end
  always_ff @(posedge core_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      event_raw_o <= '0;
    end
    else
    begin
      event_raw_o <= ev_sync;
    end
  end
  // ****************************************
  // Read data
  // ****************************************
  always_comb
  begin
    unique case (reg_addr_i)
      PIM_OFS_TOP_FIRST: next_rdata = top_event_mask_first;
      PIM_OFS_TOP_SECOND: next_rdata = top_event_mask_second;
      PIM_OFS_REGULATOR: next_rdata = regulator_event_mask;
      default: next_rdata = 8'h00;
    endcase
  end
  // Registered read data
  always_ff @(posedge core_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      reg_rdata_o <= 8'h00;
    end
    else if (reg_rd_i)
    begin
      reg_rdata_o <= next_rdata;
    end
  end
endmodule

/* File: verif/pim_mask_regs_assertions.sv */
// Checker for the interrupt mask block; shadows the three masks.
// Assumes it is bound to pim_mask_regs and sees only its ports.
`timescale 1ns/100ps
module pim_mask_regs_assertions
  import pim_pkg::*;
(
  // Clock, reset, register port
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic [7:0] reg_rdata_o,
  // Defaults, events, flags
  input wire logic [7:0] otp_top_first_i,
  input wire logic otp_reg_reset_i,
  input wire logic [7:0] otp_regulator_i,
  input wire logic [pim_pkg::PIM_NUM_EVT-1:0] event_i,
  input wire logic [pim_pkg::PIM_NUM_EVT-1:0] irq_flag_o,
  input wire logic irq_o,
  input wire logic [pim_pkg::PIM_NUM_EVT-1:0] event_raw_o
);
  logic ld; // Load edge pending
  logic [2:0] up; // Cycles since reset
  logic [7:0] m1, m2, m3; // Shadow masks
  logic [10:0] mk, mq, raw_q; // Event masks, delayed copies
  logic [7:0] rd_exp; // Expected read byte
  // ****************************************
  // Shadow of loads and writes
  // ****************************************
  always_ff @(posedge core_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      ld <= 1'b1;
      m1 <= 8'h00;
      m2 <= 8'h00;
      m3 <= 8'h00;
    end
    else if (ld)
    begin
      ld <= 1'b0;
      m1 <= otp_top_first_i;
      m2 <= {7'h00, otp_reg_reset_i};
      m3 <= otp_regulator_i & PIM_WMASK_REGULATOR;
    end
    else if (reg_wr_i)
    begin
      if (reg_addr_i == PIM_OFS_TOP_FIRST) m1 <= reg_wdata_i;
      if (reg_addr_i == PIM_OFS_TOP_SECOND) m2 <= {reg_wdata_i[7:1], m2[0]};
      if (reg_addr_i == PIM_OFS_REGULATOR) m3 <= reg_wdata_i & PIM_WMASK_REGULATOR;
    end
  end
  // Delayed copies; masks read as set until loaded
  always_ff @(posedge core_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      up <= 3'h0;
      mq <= 11'h7ff;
      raw_q <= 11'h000;
    end
    else
    begin
      up <= (up == 3'h7) ? up : up + 3'h1;
      mq <= mk;
      raw_q <= event_raw_o;
    end
  end
  assign mk = {m3[0], m3[2], m3[3], m3[4], m3[6], m3[7], m2[0], m1[0], m1[2], m1[4], m1[7]};
  // Expected byte per address
  always_comb
  begin
    case (reg_addr_i)
      PIM_OFS_TOP_FIRST: rd_exp = m1;
      PIM_OFS_TOP_SECOND: rd_exp = m2;
      PIM_OFS_REGULATOR: rd_exp = m3;
      default: rd_exp = 8'h00;
    endcase
  end
  // ****************************************
  // Properties
  // ****************************************
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_b_i);
  sequence s_read;
    reg_rd_i && !reg_wr_i;
  endsequence
  sequence s_quiet;
    (up == 3'h7 && $stable(event_i))[*4];
  endsequence
  AST_READ_DATA: assert property (s_read |=> reg_rdata_o == $past(rd_exp))
    else $error("read data wrong");
  AST_RDATA_HOLD: assert property (!reg_rd_i |=> $stable(reg_rdata_o))
    else $error("read data moved");
  AST_IRQ_OR: assert property (irq_o == |irq_flag_o)
    else $error("irq differs from flags");
  AST_FLAG_STICKY: assert property (($past(irq_flag_o) & ~irq_flag_o) == 11'h000)
    else $error("flag fell");
  AST_FLAG_MASKED: assert property ((irq_flag_o & ~$past(irq_flag_o) & mk & mq) == 11'h000)
    else $error("masked event flagged");
  AST_FLAG_CAUSE: assert property ((irq_flag_o & ~$past(irq_flag_o) & ~(event_raw_o | raw_q)) == 11'h000)
    else $error("flag without event");
  AST_RAW_LIVE: assert property (s_quiet |-> event_raw_o == event_i)
    else $error("raw state stale");
  for (genvar k = 0; k < PIM_NUM_EVT; k++)
  begin : g_set
    AST_FLAG_SET: assert property (up == 3'h7 && event_raw_o[k] && !raw_q[k] && !mk[k] && !mq[k] |-> ##[0:3] irq_flag_o[k])
      else $error("unmasked event not flagged");
  end
endmodule
bind pim_mask_regs pim_mask_regs_assertions i_chk (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i),
  .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
  .reg_rdata_o(reg_rdata_o), .otp_top_first_i(otp_top_first_i), .otp_reg_reset_i(otp_reg_reset_i),
  .otp_regulator_i(otp_regulator_i), .event_i(event_i), .irq_flag_o(irq_flag_o), .irq_o(irq_o),
  .event_raw_o(event_raw_o));

/* File: verif/pim_mask_regs_tb.sv */
// Testbench for the interrupt mask block: reads, writes and events.
// Assumes the checker binds itself to the design.
`timescale 1ns/100ps
module pim_mask_regs_tb;
  import pim_pkg::*;
  logic clk = 1'b0; // 10 MHz clock
  logic rst_b = 1'b0; // Active-low reset
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic [10:0] ev = 11'h000; // Event levels
  logic [7:0] otp_first = 8'h84; // OTP default of first mask
  logic otp_rr = 1'b1; // OTP register reset mask bit
  logic [7:0] rdata;
  logic [10:0] flag, raw;
  logic irq;
  int n_mismatch = 0;
  int num_checks = 0;
  int cyc = 0;
  always #50 clk = ~clk;
  pim_mask_regs i_dut (.core_clk_i(clk), .rst_b_i(rst_b), .reg_wr_i(wr), .reg_rd_i(rd),
    .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_rdata_o(rdata), .otp_top_first_i(otp_first),
    .otp_reg_reset_i(otp_rr), .otp_regulator_i(8'hff), .event_i(ev), .irq_flag_o(flag),
    .irq_o(irq), .event_raw_o(raw));
  // ****************************************
  // Tasks
  // ****************************************
  task automatic chk(input logic [10:0] got, input logic [10:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("FAIL %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    chk({3'h0, rdata}, {3'h0, e});
  endtask
  // All events high, then low; check raw, flags, irq
  task automatic fire(input logic [10:0] e);
    @(posedge clk);
    ev <= 11'h7ff;
    repeat (5) @(posedge clk);
    @(negedge clk);
    chk(raw, 11'h7ff);
    @(posedge clk);
    ev <= 11'h000;
    repeat (6) @(posedge clk);
    @(negedge clk);
    chk(flag, e);
    chk({10'h000, irq}, {10'h000, |e});
  endtask
  task automatic do_reset();
    @(posedge clk);
    rst_b <= 1'b0;
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    repeat (2) @(posedge clk);
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
    begin
      $display("STATUS OK");
    end
    else
    begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // Cycle ceiling against hangs
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      n_mismatch++;
      end_of_test();
    end
  end
  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    do_reset();
    rd_reg(PIM_OFS_TOP_FIRST, 8'h84);
    rd_reg(PIM_OFS_TOP_SECOND, 8'h01);
    rd_reg(PIM_OFS_REGULATOR, 8'hdd);
    rd_reg(8'h23, 8'h00);
    wr_reg(PIM_OFS_TOP_SECOND, 8'hfe);
    rd_reg(PIM_OFS_TOP_SECOND, 8'hff);
    chk({10'h000, irq}, 11'h000);
    fire(11'h00a);
    wr_reg(PIM_OFS_TOP_FIRST, 8'h6a);
    wr_reg(PIM_OFS_REGULATOR, 8'h22);
    wr_reg(8'h23, 8'hff);
    rd_reg(PIM_OFS_TOP_FIRST, 8'h6a);
    rd_reg(PIM_OFS_REGULATOR, 8'h00);
    chk(flag, 11'h00a);
    fire(11'h7ef);
    // New OTP defaults, taken at the load edge after reset
    @(posedge clk);
    otp_first <= 8'h11;
    otp_rr <= 1'b0;
    do_reset();
    rd_reg(PIM_OFS_TOP_FIRST, 8'h11);
    rd_reg(PIM_OFS_TOP_SECOND, 8'h00);
    chk(flag, 11'h000);
    fire(11'h015);
    end_of_test();
  end
endmodule
